/* hdl/pdc_consts.vh */
// Constants for the clock output control block: register map, fields, widths
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PDC_REG_CTRL     8'h00
`define PDC_REG_FBINT    8'h04
`define PDC_REG_FBFRAC   8'h08
`define PDC_REG_STATUS   8'h0c
`define PDC_REG_OUTCFG0  8'h10
`define PDC_REG_CASCADE  8'h20

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PDC_CTRL_EN_LSB      0
`define PDC_CTRL_SRC_LSB     4
`define PDC_CTRL_DLLMODE     8
`define PDC_CTRL_PVT         9
`define PDC_CTRL_DDIV_LSB    10
`define PDC_CTRL_SHIFT_LSB   12

// ----------------------------------------------------------------
// Output config register fields
// ----------------------------------------------------------------
`define PDC_OC_SEL_LSB    0
`define PDC_OC_FORCE      3
`define PDC_OC_DIV_LSB    4
`define PDC_OC_DLY_LSB    12

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define PDC_OC_RESET      32'h0000_0010
`define PDC_FBINT_RESET   12'h010
`define PDC_NUM_OUT       4
`define PDC_FRAC_W        24
`define PDC_DIV_MAX       7'h7f
`define PDC_VCO4_TICKS    5'h1f
`define PDC_AXI_OKAY      2'b00
`define PDC_AXI_SLVERR    2'b10

`endif

/* hdl/pdc_out_chan.v */
// One PLL output: phase pick, gating, divider and delayed release
`timescale 1ns/1ns
`include "pdc_consts.vh"

module pdc_out_chan (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [7:0] phases,     // Eight phase levels
  input  wire       tick,       // One VCO/4 cycle has passed
  input  wire       run_req,    // Start when high, stop when low
  input  wire [2:0] cfg_sel,    // Phase choice from software
  input  wire       cfg_force,  // Hold output low
  input  wire [6:0] cfg_div,    // Divide ratio
  input  wire [2:0] cfg_dly,    // Release delay in VCO/4 cycles
  output reg        clk_out,    // Gated, divided clock
  output reg        running     // Output is in the run state
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] ST_STOP = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  reg  [2:0] st_q;      // Current state
  reg  [2:0] sel_q;     // Active phase choice
  reg        force_q;   // Active force-low
  reg  [6:0] div_q;     // Active ratio
  reg  [6:0] cnt_q;     // Divider count
  reg        lvl_q;     // Divided level
  reg  [2:0] dly_q;     // Release countdown
  reg        prev_q;    // Selected phase one cycle ago
  wire       sel_lvl;   // Selected phase level
  wire       rise;      // Selected phase rising
  wire       gated;     // Level that goes out
  wire [6:0] cnt_n;     // Next divider count

  assign sel_lvl = phases[sel_q];
  assign rise    = sel_lvl & ~prev_q;
  assign cnt_n   = (cnt_q == div_q - 7'h01) ? 7'h00 : cnt_q + 7'h01;
  // Ratio 1 passes the phase itself; zero reads as 1 as well
  assign gated   = st_q[2] & ~force_q &
                   ((div_q <= 7'h01) ? sel_lvl : lvl_q);

  // ----------------------------------------------------------------
  // Control sequence
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= ST_STOP;
      sel_q   <= 3'h0;
      force_q <= 1'b1;
      div_q   <= 7'h01;
      cnt_q   <= 7'h00;
      lvl_q   <= 1'b0;
      dly_q   <= 3'h0;
      prev_q  <= 1'b0;
      clk_out <= 1'b0;
      running <= 1'b0;
    end else begin
      prev_q  <= sel_lvl;
      clk_out <= gated;
      running <= st_q[2];
      case (st_q)
        ST_STOP: begin
          // Settings only move while stopped, so no running edge is cut
          sel_q   <= cfg_sel;
          force_q <= cfg_force;
          div_q   <= cfg_div;
          dly_q   <= cfg_dly;
          cnt_q   <= cfg_div - 7'h01;
          lvl_q   <= 1'b0;
          // Leave only while the phase is low, so the first high is whole
          if (run_req && !phases[cfg_sel]) begin
            st_q <= (cfg_dly == 3'h0) ? ST_RUN : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!run_req) begin
            st_q <= ST_STOP;
          end else if (tick) begin
            dly_q <= dly_q - 3'h1;
            if (dly_q == 3'h1 && !sel_lvl) begin
              st_q <= ST_RUN;
            end
          end else if (dly_q == 3'h0 && !sel_lvl) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (rise) begin
            cnt_q <= cnt_n;
            lvl_q <= (cnt_n < {1'b0, div_q[6:1]}) ? 1'b1 : 1'b0;
          end
          // Stop only while the outgoing level is low
          if (!run_req && !gated) begin
            st_q <= ST_STOP;
          end
        end
        default: begin
          st_q <= ST_STOP;
        end
      endcase
    end
  end

endmodule

/* hdl/pdc_clock_ctrl.v */
// Top of the PLL/DLL clock output controller with its AXI4-Lite registers
`timescale 1ns/1ns
`include "pdc_consts.vh"

module pdc_clock_ctrl #(
  parameter NUM_LANES    = 4,  // Memory lanes sharing the tap count
  parameter TAPS_PER_CYC = 4   // Delay taps per aclk period
) (
  input  wire                   aclk,
  input  wire                   aresetn,
  // AXI4-Lite slave
  input  wire [7:0]             s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output reg                    s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output reg                    s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [7:0]             s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output reg                    s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // Fabric and clock side
  input  wire [3:0]             fab_run,       // Fabric start/stop per output
  input  wire                   dll_ref_clk,   // DLL input clock
  input  wire [NUM_LANES-1:0]   lane_upd,      // Per-lane tap update enable
  output wire [3:0]             pll_clk_out,   // Output clocks
  output reg  [11:0]            fb_div_q,      // Feedback divide this cycle
  output reg                    dll_fix_clk_q, // Fixed undivided DLL output
  output reg                    dll_div_clk_q, // Divided, shifted DLL output
  output reg  [NUM_LANES*8-1:0] lane_tap_q,    // Strobe delay per lane
  output reg  [7:0]             casc_tap_q     // Fine delay for PLL cascade
);

  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  reg  [14:0] ctrl_q;        // Control register
  reg  [11:0] fbint_q;       // Feedback integer part
  reg  [23:0] fbfrac_q;      // Feedback fraction
  reg  [31:0] oc_q [0:3];    // Output configs
  reg  [7:0]  casc_fix_q;    // Uncompensated cascade taps
  reg  [3:0]  fab_m_q;       // Fabric run, first stage
  reg  [3:0]  fab_s_q;       // Fabric run, second stage
  reg         ref_m_q;       // Ref clock, first stage
  reg         ref_s_q;       // Ref clock, second stage
  reg         ref_p_q;       // Ref clock, one cycle later
  reg  [2:0]  ph_cnt_q;      // Phase position
  reg  [4:0]  vco4_q;        // VCO/4 cycle counter
  reg  [23:0] acc_q;         // Fraction accumulator
  reg  [7:0]  per_cnt_q;     // Ref period in aclk cycles
  reg  [7:0]  tap_q;         // Quarter-period tap count
  reg  [1:0]  ddiv_q;        // DLL divide counter
  reg  [7:0]  shift_q;       // DLL phase shift line
  reg  [7:0]  aw_addr_q;     // Latched write address
  reg  [31:0] w_data_q;      // Latched write data
  reg  [3:0]  w_strb_q;      // Latched strobes
  reg         aw_have_q;     // Write address held
  reg         w_have_q;      // Write data held
  wire [7:0]  phases;        // Eight phase levels
  wire [3:0]  running;       // Per-output run state
  wire [3:0]  run_req;       // Per-output run request
  wire        tick;          // VCO/4 tick
  wire        ref_rise;      // Ref clock rising
  wire [24:0] acc_sum;       // Accumulator plus fraction
  wire [15:0] tap_full;      // Scaled period
  reg  [31:0] rd_word;       // Read mux
  reg         rd_ok;         // Read hits a register
  reg  [31:0] wr_word;       // Merged write word
  reg         wr_ok;         // Write hits a register
  integer     i, j, k;   // Loop indices, one per process

  assign tick     = (vco4_q == 5'h00);
  assign ref_rise = ref_s_q & ~ref_p_q;
  assign acc_sum  = {1'b0, acc_q} + {1'b0, fbfrac_q};
  assign tap_full = per_cnt_q * TAPS_PER_CYC[7:0];

  // ----------------------------------------------------------------
  // Eight phases, 45 degrees apart, one aclk per step
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_ph
      localparam [2:0] K = g;
      wire [2:0] off = ph_cnt_q - K;
      assign phases[g] = ~off[2];
    end
    for (g = 0; g < 4; g = g + 1) begin : gen_out
      // Source bit picks fabric control over the register enable
      assign run_req[g] = ctrl_q[`PDC_CTRL_SRC_LSB + g] ?
                          fab_s_q[g] : ctrl_q[`PDC_CTRL_EN_LSB + g];
      pdc_out_chan pdc_out_chan_i (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .phases    (phases),
        .tick      (tick),
        .run_req   (run_req[g]),
        .cfg_sel   (oc_q[g][`PDC_OC_SEL_LSB +: 3]),
        .cfg_force (oc_q[g][`PDC_OC_FORCE]),
        .cfg_div   (oc_q[g][`PDC_OC_DIV_LSB +: 7]),
        .cfg_dly   (oc_q[g][`PDC_OC_DLY_LSB +: 3]),
        .clk_out   (pll_clk_out[g]),
        .running   (running[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Phase source, fractional feedback, synchronisers
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph_cnt_q <= 3'h0;
      vco4_q   <= 5'h00;
      acc_q    <= 24'h000000;
      fb_div_q <= `PDC_FBINT_RESET;
      fab_m_q  <= 4'h0;
      fab_s_q  <= 4'h0;
      ref_m_q  <= 1'b0;
      ref_s_q  <= 1'b0;
      ref_p_q  <= 1'b0;
    end else begin
      ph_cnt_q <= ph_cnt_q + 3'h1;
      vco4_q   <= (vco4_q == `PDC_VCO4_TICKS) ? 5'h00 : vco4_q + 5'h01;
      fab_m_q  <= fab_run;
      fab_s_q  <= fab_m_q;
      ref_m_q  <= dll_ref_clk;
      ref_s_q  <= ref_m_q;
      ref_p_q  <= ref_s_q;
      // Carry of the accumulator dithers the integer ratio per ref cycle
      if (ref_rise) begin
        acc_q    <= acc_sum[23:0];
        fb_div_q <= fbint_q + {11'h000, acc_sum[24]};
      end
    end
  end

  // ----------------------------------------------------------------
  // DLL: tap measurement, lane distribution, injection outputs
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_q     <= 8'h00;
      tap_q         <= 8'h00;
      lane_tap_q    <= {NUM_LANES*8{1'b0}};
      casc_tap_q    <= 8'h00;
      ddiv_q        <= 2'h0;
      shift_q       <= 8'h00;
      dll_fix_clk_q <= 1'b0;
      dll_div_clk_q <= 1'b0;
    end else begin
      if (!ctrl_q[`PDC_CTRL_DLLMODE]) begin
        // Time reference: one period in taps, a quarter of it kept
        if (ref_rise) begin
          per_cnt_q <= 8'h01;
          tap_q     <= tap_full[9:2];
        end else if (per_cnt_q != 8'hff) begin
          per_cnt_q <= per_cnt_q + 8'h01;
        end
        dll_fix_clk_q <= 1'b0;
        dll_div_clk_q <= 1'b0;
      end else begin
        // Injection delay: fixed copy and a divided, shifted copy
        if (ref_rise) begin
          ddiv_q <= ddiv_q + 2'h1;
        end
        case (ctrl_q[`PDC_CTRL_DDIV_LSB +: 2])
          2'h1:    shift_q <= {shift_q[6:0], ddiv_q[0]};
          2'h2:    shift_q <= {shift_q[6:0], ddiv_q[1]};
          default: shift_q <= {shift_q[6:0], ref_s_q};
        endcase
        dll_fix_clk_q <= ref_s_q;
        dll_div_clk_q <= shift_q[ctrl_q[`PDC_CTRL_SHIFT_LSB +: 3]];
      end
      // Lanes take the shared count only when their own update is on
      for (j = 0; j < NUM_LANES; j = j + 1) begin
        if (lane_upd[j]) begin
          lane_tap_q[j*8 +: 8] <= tap_q;
        end
      end
      // Without compensation the cascade uses a fixed software count
      casc_tap_q <= ctrl_q[`PDC_CTRL_PVT] ? tap_q : casc_fix_q;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  always @* begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      `PDC_REG_CTRL:          rd_word = {17'h00000, ctrl_q};
      `PDC_REG_FBINT:         rd_word = {20'h00000, fbint_q};
      `PDC_REG_FBFRAC:        rd_word = {8'h00, fbfrac_q};
      `PDC_REG_STATUS:        rd_word = {16'h0000, tap_q, 4'h0, running};
      `PDC_REG_OUTCFG0:       rd_word = oc_q[0];
      `PDC_REG_OUTCFG0 + 8'h4: rd_word = oc_q[1];
      `PDC_REG_OUTCFG0 + 8'h8: rd_word = oc_q[2];
      `PDC_REG_OUTCFG0 + 8'hc: rd_word = oc_q[3];
      `PDC_REG_CASCADE:       rd_word = {24'h000000, casc_fix_q};
      default:                rd_ok   = 1'b0;
    endcase
  end

  always @* begin
    wr_ok   = 1'b1;
    wr_word = 32'h0000_0000;
    case (aw_addr_q)
      `PDC_REG_CTRL:    wr_word = {17'h00000, ctrl_q};
      `PDC_REG_FBINT:   wr_word = {20'h00000, fbint_q};
      `PDC_REG_FBFRAC:  wr_word = {8'h00, fbfrac_q};
      `PDC_REG_CASCADE: wr_word = {24'h000000, casc_fix_q};
      `PDC_REG_OUTCFG0, `PDC_REG_OUTCFG0 + 8'h4,
      `PDC_REG_OUTCFG0 + 8'h8, `PDC_REG_OUTCFG0 + 8'hc:
                        wr_word = oc_q[aw_addr_q[3:2]];
      default:          wr_ok   = 1'b0;
    endcase
    for (k = 0; k < 4; k = k + 1) begin
      if (w_strb_q[k]) begin
        wr_word[k*8 +: 8] = w_data_q[k*8 +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: address and data in either order, one at a time
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PDC_AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `PDC_AXI_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      ctrl_q        <= 15'h0000;
      fbint_q       <= `PDC_FBINT_RESET;
      fbfrac_q      <= 24'h000000;
      casc_fix_q    <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        oc_q[i] <= `PDC_OC_RESET;
      end
    end else begin
      // Ready is offered one cycle after valid and dropped on the take
      s_axi_awready <= s_axi_awvalid & ~aw_have_q & ~s_axi_awready;
      s_axi_wready  <= s_axi_wvalid & ~w_have_q & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `PDC_AXI_OKAY : `PDC_AXI_SLVERR;
        case (aw_addr_q)
          `PDC_REG_CTRL:    ctrl_q     <= wr_word[14:0];
          `PDC_REG_FBINT:   fbint_q    <= wr_word[11:0];
          `PDC_REG_FBFRAC:  fbfrac_q   <= wr_word[23:0];
          `PDC_REG_CASCADE: casc_fix_q <= wr_word[7:0];
          `PDC_REG_OUTCFG0, `PDC_REG_OUTCFG0 + 8'h4,
          `PDC_REG_OUTCFG0 + 8'h8, `PDC_REG_OUTCFG0 + 8'hc:
                            oc_q[aw_addr_q[3:2]] <= wr_word;
          default: ;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Read: address taken, data a cycle later, held until rready
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? `PDC_AXI_OKAY : `PDC_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* test/pdc_clock_ctrl_sva.sv */
// Checker for the clock output controller, bound to its top ports
`timescale 1ns/1ns
`include "pdc_consts.vh"

module pdc_clock_ctrl_sva #(
  parameter NUM_LANES = 4  // Lanes sharing the tap count
) (
  input wire                   aclk,
  input wire                   aresetn,
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire [1:0]             s_axi_bresp,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_bready,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [31:0]            s_axi_rdata,
  input wire [1:0]             s_axi_rresp,
  input wire                   s_axi_rvalid,
  input wire                   s_axi_rready,
  input wire [NUM_LANES-1:0]   lane_upd,
  input wire [3:0]             pll_clk_out,
  input wire [NUM_LANES*8-1:0] lane_tap_q
);
  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aw_ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  b_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  r_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  no_ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  err_data_zero_a: assert property (s_axi_rvalid && s_axi_rresp == `PDC_AXI_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  // ----------------------------------------
  // Clock outputs: no high pulse on output 0 or low pulse on output 1 shorter than half a phase period; lane 1 tap hold
  // ----------------------------------------
  clk_high_width_a: assert property ($rose(pll_clk_out[0]) |=> pll_clk_out[0] [*3])
    else $error("short high pulse");
  clk_low_width_a: assert property ($fell(pll_clk_out[1]) |=> !pll_clk_out[1] [*3])
    else $error("short low pulse");
  lane_hold_a: assert property (!lane_upd[1] |=> $stable(lane_tap_q[15:8]))
    else $error("lane tap moved without update");
endmodule

/* test/pdc_fab_model.sv */
// Fabric side model: start/stop requests and the DLL reference clock
`timescale 1ns/1ns

module pdc_fab_model #(
  parameter REF_HALF = 10  // Clock cycles per half reference period
) (
  input  wire       aclk,
  input  wire [3:0] run_cmd,     // Requested start/stop from the bench
  output reg  [3:0] fab_run = 4'h0,     // Start/stop level to the block
  output reg        dll_ref_clk = 1'b0  // Free running reference clock
);
  reg [7:0] cnt_q = 8'h00;  // Half period counter

  // Requests change just after an edge, as real fabric flops would
  always @(posedge aclk) begin
    fab_run <= run_cmd;
    if (cnt_q == 8'(REF_HALF - 1)) begin
      cnt_q <= 8'h00;
      dll_ref_clk <= ~dll_ref_clk;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* test/pdc_clock_ctrl_tb.sv */
// Testbench for the clock output controller: registers, clocks, DLL
`timescale 1ns/1ns
`include "pdc_consts.vh"

module pdc_clock_ctrl_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [1:0]  lane_upd = 2'b01;  // Lane 1 frozen at first
  logic [3:0]  run_cmd = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, ref_clk, fix_clk, div_clk;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  fab_run, pll_clk;
  wire  [11:0] fb_div;
  wire  [15:0] lane_tap;
  wire  [7:0]  casc_tap;
  wire  [5:0]  mon = {div_clk, fix_clk, pll_clk};  // Clocks under measurement
  int          n_errors = 0, compares = 0;

  pdc_clock_ctrl #(.NUM_LANES(2), .TAPS_PER_CYC(4)) pdc_clock_ctrl_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fab_run(fab_run), .dll_ref_clk(ref_clk), .lane_upd(lane_upd), .pll_clk_out(pll_clk),
    .fb_div_q(fb_div), .dll_fix_clk_q(fix_clk), .dll_div_clk_q(div_clk),
    .lane_tap_q(lane_tap), .casc_tap_q(casc_tap));

  pdc_fab_model #(.REF_HALF(10)) pdc_fab_model_i (
    .aclk(aclk), .run_cmd(run_cmd), .fab_run(fab_run), .dll_ref_clk(ref_clk));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Step past an edge so that its updates have landed
  task tick;
    @(posedge aclk);
    #1;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s", $time, m);
      n_errors++;
    end
  endtask

  task end_sim;
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Valids and ready go up at once; each valid drops at its own take
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 60);
    bready <= 1'b0;
    chk({30'h0, (bvalid === 1'b1) ? bresp : 2'bxx}, {30'h0, er}, "write response");
    @(posedge aclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 60);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er}, "read response");
    chk((rvalid === 1'b1) ? rdata : 32'hx, exp, "read data");
    @(posedge aclk);
  endtask

  task until_hi(input int i, output int n);
    n = 0;
    while (mon[i] !== 1'b1 && n < 3000) begin tick; n++; end
  endtask

  // High time and period of one watched clock, from a rising edge
  task meas(input int i, output int hi, output int per);
    int n;
    hi = 0;
    n = 0;
    while (mon[i] !== 1'b0 && n < 3000) begin tick; n++; end
    until_hi(i, n);
    while (mon[i] === 1'b1 && hi < 3000) begin tick; hi++; end
    until_hi(i, per);
    per = per + hi;
  endtask

  task stay_low(input int i, input int cycles);
    bit seen;
    seen = 0;
    repeat (cycles) begin tick; if (mon[i] !== 1'b0) seen = 1; end
    chk({31'h0, seen}, 32'h0, "output not held low");
  endtask

  function automatic logic [31:0] oc(input logic [2:0] sel, input logic frc,
                                     input logic [6:0] div, input logic [2:0] dly);
    return {17'h0, dly, 1'b0, div, frc, sel};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    chk({20'h0, fb_div}, 32'h10, "feedback reset value");
    rd(`PDC_REG_OUTCFG0, `PDC_OC_RESET, `PDC_AXI_OKAY);
    wr(`PDC_REG_FBFRAC, 32'hffab_cdef, `PDC_AXI_OKAY);
    rd(`PDC_REG_FBFRAC, 32'h00ab_cdef, `PDC_AXI_OKAY);
    wr(8'h40, 32'h1, `PDC_AXI_SLVERR);
    rd(8'h40, 32'h0, `PDC_AXI_SLVERR);
  endtask

  task t_phase;
    int hi, per, off;
    wr(`PDC_REG_OUTCFG0, oc(3'h0, 1'b0, 7'h1, 3'h0), `PDC_AXI_OKAY);
    wr(`PDC_REG_OUTCFG0 + 8'h4, oc(3'h2, 1'b0, 7'h1, 3'h0), `PDC_AXI_OKAY);
    wr(`PDC_REG_OUTCFG0 + 8'h8, oc(3'h5, 1'b1, 7'h1, 3'h0), `PDC_AXI_OKAY);
    wr(`PDC_REG_CTRL, 32'h7, `PDC_AXI_OKAY);
    repeat (100) tick;
    meas(0, hi, per);
    chk(hi, 4, "ratio 1 high time");
    until_hi(1, off);
    chk(off, 2, "phase offset");
    chk(per, 8, "ratio 1 period");
    stay_low(2, 40);
  endtask

  // New ratio while stopped takes hold; a write while running is ignored
  task t_div;
    int hi, per, k;
    int r[2] = '{3, 127};
    for (k = 0; k < 2; k++) begin
      wr(`PDC_REG_CTRL, 32'h6, `PDC_AXI_OKAY);
      repeat (20) tick;
      stay_low(0, 16);
      wr(`PDC_REG_OUTCFG0, oc(3'h0, 1'b0, 7'(r[k]), 3'h0), `PDC_AXI_OKAY);
      wr(`PDC_REG_CTRL, 32'h7, `PDC_AXI_OKAY);
      meas(0, hi, per);
      chk(hi, (r[k] / 2) * 8, "divided high time");
      chk(per, r[k] * 8, "divided period");
      wr(`PDC_REG_OUTCFG0, oc(3'h0, 1'b0, 7'h1, 3'h0), `PDC_AXI_OKAY);
      meas(0, hi, per);
      chk(per, r[k] * 8, "ratio changed while running");
    end
  endtask

  task t_dly;
    int n;
    wr(`PDC_REG_CTRL, 32'h6, `PDC_AXI_OKAY);
    repeat (1100) tick;
    wr(`PDC_REG_OUTCFG0, oc(3'h0, 1'b0, 7'h1, 3'h7), `PDC_AXI_OKAY);
    wr(`PDC_REG_CTRL, 32'h7, `PDC_AXI_OKAY);
    until_hi(0, n);
    chk(n >= 180 && n <= 280, 1, "release delay");
  endtask

  task t_fab;
    int hi, per;
    wr(`PDC_REG_CTRL, 32'h80, `PDC_AXI_OKAY);
    run_cmd <= 4'h9;
    repeat (60) tick;
    meas(3, hi, per);
    chk(per, 8, "fabric started output");
    stay_low(0, 16);
    run_cmd <= 4'h0;
    repeat (20) tick;
    stay_low(3, 16);
  endtask

  task t_dll;
    int hi, per;
    wr(`PDC_REG_CASCADE, 32'h55, `PDC_AXI_OKAY);
    repeat (200) tick;
    chk(casc_tap, 8'h55, "cascade taps");
    chk(lane_tap[7:0], 8'h14, "quarter period taps");
    chk(lane_tap[15:8], 8'h00, "frozen lane");
    rd(`PDC_REG_STATUS, 32'h0000_1400, `PDC_AXI_OKAY);
    lane_upd <= 2'b11;
    repeat (200) tick;
    chk(lane_tap[15:8], 8'h14, "shared taps on lane 1");
    wr(`PDC_REG_CTRL, 32'h1b00, `PDC_AXI_OKAY);
    repeat (200) tick;
    meas(4, hi, per);
    chk(per, 20, "fixed DLL clock period");
    meas(5, hi, per);
    chk(per, 80, "divided DLL clock period");
    chk(casc_tap, 8'h14, "compensated cascade taps");
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) tick;
    aresetn <= 1'b1;
    repeat (4) tick;
    t_regs;
    t_phase;
    t_div;
    t_dly;
    t_fab;
    t_dll;
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    end_sim;
  end
endmodule

bind pdc_clock_ctrl pdc_clock_ctrl_sva #(.NUM_LANES(NUM_LANES)) pdc_clock_ctrl_sva_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .lane_upd(lane_upd),
  .pll_clk_out(pll_clk_out), .lane_tap_q(lane_tap_q));
